// ==== fsc_host.sv ====
// Serial host model that sends mode 0 frames to the register bank.
// Assumes the bench calls frame() only while the bank is out of reset.
`timescale 1ns/1ns
module fsc_host (
  output logic spi_clk,
  output logic spi_cs_n,
  output logic spi_si,
  input wire logic spi_so,
  input wire logic spi_so_oe
);
  // ----------------------------------------
  // Frame driver, 64 ns link clock
  // ----------------------------------------
  logic oe_all;
  initial begin
    oe_all = 1'b0;
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
  end
  // Whole bytes MSB first, then nr read bytes
  task automatic frame(input int nt, input logic [47:0] tx,
      input int nr, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    oe_all = 1'b1;
    spi_cs_n = 1'b0;
    for (i = nt * 8 - 1; i >= -nr * 8; i--) begin
      spi_si = (i >= 0) ? tx[i] : ~spi_si;
      #32 spi_clk = 1'b1;
      if (i < 0) rx = {rx[6:0], spi_so};
      if (i < 0) oe_all = oe_all & spi_so_oe;
      #32 spi_clk = 1'b0;
    end
    #32 spi_cs_n = 1'b1;
    spi_si = ~spi_si;
    #200;
  endtask
endmodule

// ==== fsc_pkg.sv ====
// Constants for the second status and first configuration registers.
// Assumes a mode 0 serial link and a core that reports erase events.
package fsc_pkg;
  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] WRITE_REGISTERS_CMD = 8'h01;
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] READ_STATUS_TWO_CMD = 8'h07;
  localparam logic [7:0] CLEAR_STATUS_CMD = 8'h30;
  localparam logic [7:0] READ_ANY_REGISTER_CMD = 8'h65;
  localparam logic [7:0] RESET_ENABLE_CMD = 8'h66;
  localparam logic [7:0] WRITE_ANY_REGISTER_CMD = 8'h71;
  localparam logic [7:0] RESET_CMD = 8'h99;
  // ----------------------------------------------------------------
  // Register addresses for the any-register commands
  // ----------------------------------------------------------------
  localparam logic [31:0] STATUS_TWO_ADDR = 32'h0080_0001;
  localparam logic [31:0] CONFIG_ONE_NV_ADDR = 32'h0000_0002;
  // ----------------------------------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam int unsigned ERASE_FAIL_BIT = 6;
  localparam int unsigned PROGRAM_FAIL_BIT = 5;
  localparam int unsigned ERASE_SUSPEND_BIT = 1;
  localparam int unsigned SCRUB_TARGET_BIT = 7;
  localparam int unsigned WRAP_SIZE_HI = 6;
  localparam int unsigned WRAP_SIZE_LO = 5;
  localparam int unsigned WRAP_ON_BIT = 4;
  localparam int unsigned QUAD_WIDTH_BIT = 1;
  localparam int unsigned ADDR_WIDTH_BIT = 0;
  localparam logic [7:0] STATUS_TWO_MASK = 8'h62;
  localparam logic [7:0] CONFIG_ONE_NV_MASK = 8'hf3;
  localparam logic [7:0] STATUS_TWO_RESET = 8'h00;
  localparam logic [7:0] CONFIG_ONE_NV_RESET = 8'h00;
  // ----------------------------------------------------------------
  // Frame lengths in bytes
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_BYTES_3 = 4'h3;
  localparam logic [3:0] ADDR_BYTES_4 = 4'h4;
  localparam logic [3:0] ONE_BYTE_FRAME = 4'h1;
  localparam logic [3:0] WRR_FRAME_BYTES = 4'h3;
  localparam logic [3:0] BYTE_COUNT_MAX = 4'hf;
  localparam logic [2:0] LAST_BIT = 3'h7;
endpackage

// ==== fsc_regs.sv ====
// Status two and config one register bank behind a serial flash link.
// Assumes mode 0 link clock, chip select low per frame, core-side events.
`timescale 1ns/1ns
module fsc_regs (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  input wire logic erase_fail_evt,
  input wire logic erase_prot_evt,
  input wire logic erase_is_chip,
  input wire logic program_fail_evt,
  input wire logic program_prot_evt,
  input wire logic erase_suspend,
  input wire logic op_busy,
  output logic busy_flag,
  output logic write_enable_latch,
  output logic erase_fail_flag,
  output logic program_fail_flag,
  output logic erase_suspend_flag,
  output logic scrub_target,
  output logic [1:0] wrap_size,
  output logic wrap_on,
  output logic quad_width,
  output logic addr_width
);
  // ----------------------------------------------------------------
  // Link side: frame counters
  // ----------------------------------------------------------------
  logic frm_rst_n;
  logic [2:0] bit_cnt_r;
  logic [3:0] byte_cnt_r;
  logic [6:0] shift_r;
  logic tx_on_r;
  logic [7:0] tx_byte_r;
  logic so_r;
  logic so_oe_r;
  logic [7:0] opcode_r;
  logic [31:0] addr_r;
  logic [7:0] data0_r;
  logic [7:0] data1_r;
  logic [3:0] frame_bytes_r;
  logic frame_seq_r;
  logic alen4_r;
  logic [7:0] sr2_shadow_r;
  logic [7:0] cr1_shadow_r;
  logic tg_s1_r;
  logic tg_s2_r;
  logic seen_r;
  logic aw_s1_r;
  logic aw_s2_r;
  // Core side state used by the link side
  logic tgl_r;
  logic [7:0] sr2_snap_r;
  logic [7:0] cr1_snap_r;
  logic addr_width_r;

  assign frm_rst_n = resetn & ~spi_cs_n;

  wire [7:0] rx_byte = {shift_r, spi_si};
  wire byte_done = (bit_cnt_r == fsc_pkg::LAST_BIT);
  wire first_byte = byte_done && (byte_cnt_r == 4'h0);
  wire [3:0] byte_cnt_inc = (byte_cnt_r == fsc_pkg::BYTE_COUNT_MAX) ?
    fsc_pkg::BYTE_COUNT_MAX : byte_cnt_r + 4'h1;
  wire is_read_any_register_cmd = (opcode_r == fsc_pkg::READ_ANY_REGISTER_CMD);
  wire is_write_any_register_cmd = (opcode_r == fsc_pkg::WRITE_ANY_REGISTER_CMD);
  wire is_wrr = (opcode_r == fsc_pkg::WRITE_REGISTERS_CMD);
  wire [3:0] alen = alen4_r ? fsc_pkg::ADDR_BYTES_4 : fsc_pkg::ADDR_BYTES_3;
  wire addr_byte = byte_done && !first_byte && (is_read_any_register_cmd || is_write_any_register_cmd) &&
    (byte_cnt_r <= alen);
  wire [31:0] addr_now = {addr_r[23:0], rx_byte};
  // Four-byte mode takes the full 32-bit address
  wire [31:0] addr_full = alen4_r ? addr_now : {8'h00, addr_now[23:0]};
  wire read_any_register_cmd_last = addr_byte && is_read_any_register_cmd && (byte_cnt_r == alen);
  wire rd_sr2_start = first_byte &&
    (rx_byte == fsc_pkg::READ_STATUS_TWO_CMD);
  // Register select for read-any-register
  wire [7:0] read_any_register_cmd_val =
    (addr_full == fsc_pkg::STATUS_TWO_ADDR) ? sr2_shadow_r :
    (addr_full == fsc_pkg::CONFIG_ONE_NV_ADDR) ? cr1_shadow_r : 8'h00;
  wire write_any_register_cmd_data = byte_done && is_write_any_register_cmd && (byte_cnt_r == alen + 4'h1);

  // Bit and byte counting, cleared by chip select
  always_ff @(posedge spi_clk or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 4'h0;
      shift_r <= 7'h00;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shift_r <= rx_byte[6:0];
      if (byte_done) begin
        byte_cnt_r <= byte_cnt_inc;
      end
    end
  end

  // Read data source, status two sent repeatedly
  always_ff @(posedge spi_clk or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      tx_on_r <= 1'b0;
      tx_byte_r <= 8'h00;
    end else if (rd_sr2_start) begin
      tx_on_r <= 1'b1;
      tx_byte_r <= sr2_shadow_r;
    end else if (read_any_register_cmd_last) begin
      tx_on_r <= 1'b1;
      tx_byte_r <= read_any_register_cmd_val;
    end else if (byte_done && tx_on_r &&
                 opcode_r == fsc_pkg::READ_STATUS_TWO_CMD) begin
      tx_byte_r <= sr2_shadow_r;
    end
  end

  // Output driven on the falling edge
  always_ff @(negedge spi_clk or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
    end else begin
      so_r <= tx_byte_r[3'h7 - bit_cnt_r];
      so_oe_r <= tx_on_r;
    end
  end

  // ----------------------------------------------------------------
  // Link side: frame contents kept after chip select rises
  // ----------------------------------------------------------------
  always_ff @(posedge spi_clk or negedge resetn) begin
    if (!resetn) begin
      opcode_r <= 8'h00;
      addr_r <= 32'h0000_0000;
      data0_r <= 8'h00;
      data1_r <= 8'h00;
      frame_bytes_r <= 4'h0;
      frame_seq_r <= 1'b0;
      alen4_r <= 1'b0;
    end else if (first_byte) begin
      opcode_r <= rx_byte;
      alen4_r <= aw_s2_r;
      frame_seq_r <= ~frame_seq_r;
      frame_bytes_r <= fsc_pkg::ONE_BYTE_FRAME;
    end else if (byte_done) begin
      frame_bytes_r <= byte_cnt_inc;
      if (addr_byte) begin
        addr_r <= addr_now;
      end
      // Sixteen data cycles: second data byte is config one
      if ((is_wrr && byte_cnt_r == 4'h1) || write_any_register_cmd_data) begin
        data0_r <= rx_byte;
      end
      if (is_wrr && byte_cnt_r == 4'h2) begin
        data1_r <= rx_byte;
      end
    end
  end

  // Register snapshots over a toggle handshake
  always_ff @(posedge spi_clk or negedge resetn) begin
    if (!resetn) begin
      tg_s1_r <= 1'b0;
      tg_s2_r <= 1'b0;
      seen_r <= 1'b0;
      aw_s1_r <= 1'b0;
      aw_s2_r <= 1'b0;
      sr2_shadow_r <= fsc_pkg::STATUS_TWO_RESET;
      cr1_shadow_r <= fsc_pkg::CONFIG_ONE_NV_RESET;
    end else begin
      tg_s1_r <= tgl_r;
      tg_s2_r <= tg_s1_r;
      aw_s1_r <= addr_width_r;
      aw_s2_r <= aw_s1_r;
      if (tg_s2_r != seen_r) begin
        seen_r <= tg_s2_r;
        sr2_shadow_r <= sr2_snap_r;
        cr1_shadow_r <= cr1_snap_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core side: frame end detection and command decode
  // ----------------------------------------------------------------
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_s3_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic last_seq_r;
  logic boot_r;
  logic wel_r;
  logic rst_en_r;
  logic e_err_r;
  logic p_err_r;
  logic es_r;
  logic busy_r;
  logic [7:0] config_one_nonvolatile_r;
  logic scrub_r;
  logic [1:0] wrap_size_r;
  logic wrap_on_r;
  logic quad_r;

  wire frame_end = cs_s2_r & ~cs_s3_r;
  wire new_frame = frame_end && (frame_seq_r != last_seq_r);
  wire accept = new_frame && !boot_r;
  // Failure flags hold the device busy
  wire busy_now = op_busy | e_err_r | p_err_r;
  wire one_byte = (frame_bytes_r == fsc_pkg::ONE_BYTE_FRAME);
  wire [31:0] addr_held = alen4_r ? addr_r : {8'h00, addr_r[23:0]};
  wire wel_go = accept && one_byte && !busy_now &&
    (opcode_r == fsc_pkg::WRITE_ENABLE_CMD);
  // Clear-status decoded under its one-byte opcode
  wire clr_go = accept && one_byte &&
    (opcode_r == fsc_pkg::CLEAR_STATUS_CMD);
  // Both write forms gated by write enable and busy
  wire wrr_go = accept && is_wrr && wel_r && !busy_now &&
    (frame_bytes_r == fsc_pkg::WRR_FRAME_BYTES);
  wire write_any_register_cmd_go = accept && is_write_any_register_cmd && wel_r && !busy_now &&
    (frame_bytes_r == alen + 4'h2) &&
    (addr_held == fsc_pkg::CONFIG_ONE_NV_ADDR);
  wire nv_wr_go = wrr_go | write_any_register_cmd_go;
  // Reserved config bits stay zero
  wire [7:0] nv_wdata = (wrr_go ? data1_r : data0_r) &
    fsc_pkg::CONFIG_ONE_NV_MASK;
  wire rst_arm_go = accept && one_byte &&
    (opcode_r == fsc_pkg::RESET_ENABLE_CMD);
  wire swrst_go = accept && one_byte && rst_en_r &&
    (opcode_r == fsc_pkg::RESET_CMD);
  wire load_go = boot_r | swrst_go;
  // Protected chip-erase sectors leave the flag alone
  wire e_set = erase_fail_evt | (erase_prot_evt & ~erase_is_chip);
  wire p_set = program_fail_evt | program_prot_evt;
  // Only events and clear-status move the flags, set wins
  wire e_err_nxt = e_set ? 1'b1 : (clr_go ? 1'b0 : e_err_r);
  wire p_err_nxt = p_set ? 1'b1 : (clr_go ? 1'b0 : p_err_r);
  wire wel_nxt = wel_go ? 1'b1 : ((nv_wr_go | clr_go) ? 1'b0 : wel_r);
  wire rst_en_nxt = new_frame ? rst_arm_go : rst_en_r;
  // Status two word, reserved bits zero
  wire [7:0] sr2_w = ({e_err_r, p_err_r, es_r} != 3'b000) ?
    (8'h00 | ({7'h00, e_err_r} << fsc_pkg::ERASE_FAIL_BIT) |
     ({7'h00, p_err_r} << fsc_pkg::PROGRAM_FAIL_BIT) |
     ({7'h00, es_r} << fsc_pkg::ERASE_SUSPEND_BIT)) :
    fsc_pkg::STATUS_TWO_RESET;
  wire snap_go = (ack_s2_r == tgl_r) &&
    ((sr2_w != sr2_snap_r) || (config_one_nonvolatile_r != cr1_snap_r));

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      last_seq_r <= 1'b0;
    end else begin
      cs_s1_r <= spi_cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      ack_s1_r <= seen_r;
      ack_s2_r <= ack_s1_r;
      if (frame_end) begin
        last_seq_r <= frame_seq_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core side: status and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      e_err_r <= 1'b0;
      p_err_r <= 1'b0;
      es_r <= 1'b0;
      busy_r <= 1'b0;
      wel_r <= 1'b0;
      rst_en_r <= 1'b0;
      config_one_nonvolatile_r <= fsc_pkg::CONFIG_ONE_NV_RESET;
    end else begin
      e_err_r <= e_err_nxt;
      p_err_r <= p_err_nxt;
      es_r <= erase_suspend;
      busy_r <= op_busy | e_err_nxt | p_err_nxt;
      wel_r <= wel_nxt;
      rst_en_r <= rst_en_nxt;
      if (nv_wr_go) begin
        config_one_nonvolatile_r <= nv_wdata;
      end
    end
  end

  // Volatile copies loaded after any reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      boot_r <= 1'b1;
      scrub_r <= 1'b0;
      wrap_size_r <= 2'b00;
      wrap_on_r <= 1'b0;
      quad_r <= 1'b0;
      addr_width_r <= 1'b0;
    end else begin
      boot_r <= 1'b0;
      if (load_go) begin
        scrub_r <= config_one_nonvolatile_r[fsc_pkg::SCRUB_TARGET_BIT];
        wrap_size_r <= config_one_nonvolatile_r[fsc_pkg::WRAP_SIZE_HI:fsc_pkg::WRAP_SIZE_LO];
        wrap_on_r <= config_one_nonvolatile_r[fsc_pkg::WRAP_ON_BIT];
        quad_r <= config_one_nonvolatile_r[fsc_pkg::QUAD_WIDTH_BIT];
        addr_width_r <= config_one_nonvolatile_r[fsc_pkg::ADDR_WIDTH_BIT];
      end
    end
  end

  // Snapshot publication toward the link side
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tgl_r <= 1'b0;
      sr2_snap_r <= fsc_pkg::STATUS_TWO_RESET;
      cr1_snap_r <= fsc_pkg::CONFIG_ONE_NV_RESET;
    end else if (snap_go) begin
      tgl_r <= ~tgl_r;
      sr2_snap_r <= sr2_w;
      cr1_snap_r <= config_one_nonvolatile_r;
    end
  end

  assign spi_so = so_r;
  assign spi_so_oe = so_oe_r;
  assign busy_flag = busy_r;
  assign write_enable_latch = wel_r;
  assign erase_fail_flag = e_err_r;
  assign program_fail_flag = p_err_r;
  assign erase_suspend_flag = es_r;
  assign scrub_target = scrub_r;
  assign wrap_size = wrap_size_r;
  assign wrap_on = wrap_on_r;
  assign quad_width = quad_r;
  assign addr_width = addr_width_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rsvd_zero;
    @(posedge core_clk) disable iff (!resetn)
      (sr2_snap_r & ~fsc_pkg::STATUS_TWO_MASK) == 8'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("status two reserved bit set");

  property p_erase_fail;
    @(posedge core_clk) disable iff (!resetn)
      erase_fail_evt |=> erase_fail_flag;
  endproperty
  a_erase_fail: assert property (p_erase_fail)
    else $error("erase failure not flagged");

  property p_erase_prot;
    @(posedge core_clk) disable iff (!resetn)
      erase_prot_evt && !erase_is_chip |=> erase_fail_flag;
  endproperty
  a_erase_prot: assert property (p_erase_prot)
    else $error("protected sector erase not flagged");

  property p_chip_prot;
    @(posedge core_clk) disable iff (!resetn)
      !erase_fail_flag && erase_prot_evt && erase_is_chip &&
      !erase_fail_evt |=> !erase_fail_flag;
  endproperty
  a_chip_prot: assert property (p_chip_prot)
    else $error("chip erase set erase failure");

  property p_prog_fail;
    @(posedge core_clk) disable iff (!resetn)
      (program_fail_evt || program_prot_evt) |=> program_fail_flag;
  endproperty
  a_prog_fail: assert property (p_prog_fail)
    else $error("program failure not flagged");

  property p_clear;
    @(posedge core_clk) disable iff (!resetn)
      clr_go && !e_set && !p_set |=> !erase_fail_flag && !program_fail_flag;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear-status left a flag set");

  property p_flag_cause;
    @(posedge core_clk) disable iff (!resetn)
      $changed(erase_fail_flag) |-> $past(e_set) || $past(clr_go);
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("erase flag moved without cause");

  property p_suspend;
    @(posedge core_clk) disable iff (!resetn)
      erase_suspend ##1 erase_suspend |=> sr2_w[fsc_pkg::ERASE_SUSPEND_BIT];
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("erase suspend not shown");

  property p_wr_gate;
    @(posedge core_clk) disable iff (!resetn)
      $changed(config_one_nonvolatile_r) |-> $past(wel_r) && !$past(busy_now);
  endproperty
  a_wr_gate: assert property (p_wr_gate)
    else $error("config written without enable or while busy");

  property p_busy;
    @(posedge core_clk) disable iff (!resetn)
      (erase_fail_flag || program_fail_flag) |-> busy_flag;
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy low while a failure flag is set");

  property p_load;
    @(posedge core_clk) disable iff (!resetn)
      load_go |=> wrap_size == $past(config_one_nonvolatile_r[6:5]) &&
        addr_width == $past(config_one_nonvolatile_r[0]) && quad_width == $past(config_one_nonvolatile_r[1]);
  endproperty
  a_load: assert property (p_load)
    else $error("volatile config not loaded from non-volatile");

  c_erase_err: cover property (@(posedge core_clk) disable iff (!resetn)
    erase_fail_flag ##[1:50] clr_go);
  c_nv_write: cover property (@(posedge core_clk) disable iff (!resetn)
    wrr_go || write_any_register_cmd_go);
  c_sw_reset: cover property (@(posedge core_clk) disable iff (!resetn)
    swrst_go);
endmodule

// ==== fsc_regs_tb_top.sv ====
// Self-checking bench for the status two and config one bank.
// Assumes fsc_host as link partner and core events from the bench.
`timescale 1ns/1ns
module fsc_regs_tb_top;
  logic core_clk, resetn, spi_clk, spi_cs_n, spi_si, spi_so, spi_so_oe;
  logic [3:0] ev;
  logic chip, susp, busy, bf, wel, ef, pf, esf, st, won, qw, aw, a4;
  logic [1:0] ws;
  logic [7:0] d;
  int n_mismatch = 0;
  int comparisons = 0;
  fsc_regs dut_u (.core_clk(core_clk), .resetn(resetn),
    .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
    .spi_so(spi_so), .spi_so_oe(spi_so_oe), .erase_fail_evt(ev[0]),
    .erase_prot_evt(ev[1]), .erase_is_chip(chip),
    .program_fail_evt(ev[2]), .program_prot_evt(ev[3]),
    .erase_suspend(susp), .op_busy(busy), .busy_flag(bf),
    .write_enable_latch(wel), .erase_fail_flag(ef),
    .program_fail_flag(pf), .erase_suspend_flag(esf),
    .scrub_target(st), .wrap_size(ws), .wrap_on(won),
    .quad_width(qw), .addr_width(aw));
  fsc_host host_u (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    host_u.frame(1, {40'h0, op}, 0, d);
  endtask
  task automatic read_status_two_cmd();
    repeat (2) host_u.frame(1, {40'h0, fsc_pkg::READ_STATUS_TWO_CMD}, 2, d);
  endtask
  task automatic read_any_register_cmd(input logic [31:0] a);
    repeat (2) begin
      if (a4) host_u.frame(5,
          {8'h0, fsc_pkg::READ_ANY_REGISTER_CMD, a}, 2, d);
      else host_u.frame(4,
          {16'h0, fsc_pkg::READ_ANY_REGISTER_CMD, a[23:0]}, 2, d);
    end
  endtask
  task automatic write_any_register_cmd(input logic [31:0] a, input logic [7:0] v, input bit en);
    if (en) cmd(fsc_pkg::WRITE_ENABLE_CMD);
    host_u.frame(5, {8'h0, fsc_pkg::WRITE_ANY_REGISTER_CMD, a[23:0], v}, 0, d);
  endtask
  task automatic pulse(input int k);
    @(negedge core_clk) ev[k] = 1'b1;
    @(negedge core_clk) ev = 4'h0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic clear_status_cmd();
    cmd(fsc_pkg::CLEAR_STATUS_CMD);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    read_status_two_cmd();
    chk(d, 8'h00, "sr2 reset");
    chk({7'h0, host_u.oe_all}, 8'h01, "so enable in read");
    chk({7'h0, spi_so_oe}, 8'h00, "so enable after frame");
    read_any_register_cmd(fsc_pkg::STATUS_TWO_ADDR);
    chk(d, 8'h00, "sr2 any reset");
    read_any_register_cmd(fsc_pkg::CONFIG_ONE_NV_ADDR);
    chk(d, 8'h00, "cfg reset");
    chk({st, ws, won, 2'h0, qw, aw}, 8'h00, "vol reset");
  endtask
  task automatic t_erase();
    pulse(0);
    read_status_two_cmd();
    chk(d, 8'h40, "erase fail");
    chk({7'h0, bf}, 8'h01, "busy on flag");
    write_any_register_cmd(fsc_pkg::STATUS_TWO_ADDR, 8'h00, 1'b1);
    read_status_two_cmd();
    chk(d, 8'h40, "flag kept");
    clear_status_cmd();
    read_status_two_cmd();
    chk(d, 8'h00, "clear_status_cmd");
    chk({7'h0, bf}, 8'h00, "busy clear");
  endtask
  task automatic t_prot();
    chip = 1'b1;
    pulse(1);
    read_status_two_cmd();
    chk(d, 8'h00, "chip erase prot");
    chip = 1'b0;
    pulse(1);
    read_status_two_cmd();
    chk(d, 8'h40, "sector prot");
    clear_status_cmd();
    pulse(2);
    read_status_two_cmd();
    chk(d, 8'h20, "program fail");
    clear_status_cmd();
    pulse(3);
    read_status_two_cmd();
    chk(d, 8'h20, "program prot");
    clear_status_cmd();
    read_status_two_cmd();
    chk(d, 8'h00, "clear_status_cmd pf");
  endtask
  task automatic t_susp();
    @(negedge core_clk) susp = 1'b1;
    read_status_two_cmd();
    chk(d, 8'h02, "suspend");
    chk({7'h0, esf}, 8'h01, "suspend flag");
    read_any_register_cmd(fsc_pkg::STATUS_TWO_ADDR);
    chk(d, 8'h02, "suspend any");
    @(negedge core_clk) susp = 1'b0;
    read_status_two_cmd();
    chk(d, 8'h00, "resume");
    @(negedge core_clk) busy = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({7'h0, bf}, 8'h01, "op busy");
    busy = 1'b0;
  endtask
  task automatic t_cfg();
    write_any_register_cmd(fsc_pkg::CONFIG_ONE_NV_ADDR, 8'hff, 1'b0);
    read_any_register_cmd(fsc_pkg::CONFIG_ONE_NV_ADDR);
    chk(d, 8'h00, "no write_enable_cmd");
    write_any_register_cmd(fsc_pkg::CONFIG_ONE_NV_ADDR, 8'hff, 1'b1);
    read_any_register_cmd(fsc_pkg::CONFIG_ONE_NV_ADDR);
    chk(d, 8'hf3, "write_any_register_cmd cfg");
    chk({7'h0, wel}, 8'h00, "enable used up");
    chk({st, ws, won, 2'h0, qw, aw}, 8'h00, "vol held");
    cmd(fsc_pkg::RESET_ENABLE_CMD);
    cmd(fsc_pkg::RESET_CMD);
    chk({7'h0, st}, 8'h01, "scrub");
    chk({6'h0, ws}, 8'h03, "wrap size");
    chk({7'h0, won}, 8'h01, "wrap on");
    chk({7'h0, qw}, 8'h01, "quad");
    chk({7'h0, aw}, 8'h01, "addr len");
    a4 = 1'b1;
    read_any_register_cmd(fsc_pkg::CONFIG_ONE_NV_ADDR);
    chk(d, 8'hf3, "four byte addr");
    cmd(fsc_pkg::WRITE_ENABLE_CMD);
    chk({7'h0, wel}, 8'h01, "enable set");
    host_u.frame(3, {24'h0, fsc_pkg::WRITE_REGISTERS_CMD, 16'h0040}, 0, d);
    read_any_register_cmd(fsc_pkg::CONFIG_ONE_NV_ADDR);
    chk(d, 8'h40, "wrr cfg");
    cmd(fsc_pkg::RESET_ENABLE_CMD);
    cmd(fsc_pkg::RESET_CMD);
    a4 = 1'b0;
    chk({st, ws, won, 2'h0, qw, aw}, 8'h40, "vol reload");
  endtask
  // ----------------------------------------
  // Clock, reset, run control
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #600000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    resetn = 1'b0;
    ev = 4'h0;
    chip = 1'b0;
    susp = 1'b0;
    busy = 1'b0;
    a4 = 1'b0;
    repeat (8) @(negedge core_clk);
    resetn = 1'b1;
    repeat (5) @(negedge core_clk);
    t_reset();
    t_erase();
    t_prot();
    t_susp();
    t_cfg();
    tally_and_finish();
  end
endmodule
